// >>> design/hsr_readout.sv
// Result and status register set of a three-axis hall sensor.
// Assumes a bus front end on mclk presents byte reads and writes.
// Engine-side inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hsr_defines.svh"
module hsr_readout (
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Conversion engine side
  input wire logic set_done,
  input wire logic conv_busy,
  input wire logic [4:0] chan_enable,
  input wire hsr_pkg::hsr_word_t temperature_channel_value,
  input wire hsr_pkg::hsr_word_t xaxis_field_value,
  input wire hsr_pkg::hsr_word_t yaxis_field_value,
  input wire hsr_pkg::hsr_word_t zaxis_field_value,
  input wire logic [12:0] angle_in,
  input wire hsr_pkg::hsr_byte_t magnitude_in,
  // Diagnostic levels
  input wire logic diag_supply_low,
  input wire logic diag_memory_crc,
  input wire logic diag_int_pin,
  input wire logic diag_clock,
  output logic data_ready
);
  import hsr_pkg::*;

  // ----------------------------------------
  // Result holders
  // ----------------------------------------
  hsr_word_t temp_q;
  hsr_word_t xaxis_q;
  hsr_word_t yaxis_q;
  hsr_word_t zaxis_q;
  hsr_word_t angle_q;
  logic [4:0] load;
  hsr_word_t angle_word;

  // Clamp keeps the reported angle inside the full turn
  always_comb begin
    angle_word = {3'b000, angle_in};
    if (angle_in > `HSR_ANGLE_MAX) begin
      angle_word = {3'b000, `HSR_ANGLE_MAX};
    end
  end

  // Only enabled channels move; disabled ones keep the last value
  assign load = chan_enable & {5{set_done}};

  hsr_result_reg u_temp (
    .mclk(mclk),
    .reset(reset),
    .load(load[`HSR_CH_TEMP]),
    .din(temperature_channel_value),
    .dout(temp_q)
  );
  hsr_result_reg u_xaxis (
    .mclk(mclk),
    .reset(reset),
    .load(load[`HSR_CH_XAXIS]),
    .din(xaxis_field_value),
    .dout(xaxis_q)
  );
  hsr_result_reg u_yaxis (
    .mclk(mclk),
    .reset(reset),
    .load(load[`HSR_CH_YAXIS]),
    .din(yaxis_field_value),
    .dout(yaxis_q)
  );
  hsr_result_reg u_zaxis (
    .mclk(mclk),
    .reset(reset),
    .load(load[`HSR_CH_ZAXIS]),
    .din(zaxis_field_value),
    .dout(zaxis_q)
  );
  hsr_result_reg u_angle (
    .mclk(mclk),
    .reset(reset),
    .load(load[`HSR_CH_ANGLE]),
    .din(angle_word),
    .dout(angle_q)
  );

  // ----------------------------------------
  // Magnitude and status
  // ----------------------------------------
  hsr_byte_t mag_d;
  hsr_byte_t mag_q;
  logic [2:0] count_d;
  logic [2:0] count_q;
  logic por_d;
  logic por_q;
  logic ready_d;
  logic ready_q;
  logic diag_d;
  logic diag_q;
  logic por_clear;

  assign por_clear = reg_wr && (reg_addr == `HSR_ADDR_CONV_STATE) &&
    reg_wdata[`HSR_ST_POR];

  always_comb begin
    mag_d = mag_q;
    count_d = count_q;
    por_d = por_q;
    ready_d = ready_q;
    if (load[`HSR_CH_ANGLE]) begin
      mag_d = magnitude_in;
    end
    if (set_done) begin
      count_d = count_q + 3'd1;
    end
    // Write one clears; power-on reset alone sets it
    if (por_clear) begin
      por_d = 1'b0;
    end
    // A completed set wins over a new conversion starting
    if (set_done) begin
      ready_d = 1'b1;
    end else if (conv_busy) begin
      ready_d = 1'b0;
    end
    diag_d = diag_supply_low | diag_memory_crc | diag_int_pin |
      diag_clock;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mag_q <= `HSR_RST_BYTE;
      count_q <= `HSR_RST_COUNT;
      por_q <= 1'b1;
      ready_q <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      mag_q <= mag_d;
      count_q <= count_d;
      por_q <= por_d;
      ready_q <= ready_d;
      diag_q <= diag_d;
    end
  end

  assign data_ready = ready_q;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  hsr_byte_t status_byte;
  hsr_byte_t rdata_d;
  hsr_byte_t rdata_q;
  logic hit_d;
  logic hit_q;

  always_comb begin
    status_byte = `HSR_RST_BYTE;
    status_byte[`HSR_ST_COUNT_HI:`HSR_ST_COUNT_LO] = count_q;
    status_byte[`HSR_ST_POR] = por_q;
    status_byte[`HSR_ST_DIAG] = diag_q;
    status_byte[`HSR_ST_READY] = ready_q;
  end

  // Unmapped addresses read zero with reg_hit low
  always_comb begin
    rdata_d = rdata_q;
    hit_d = hit_q;
    if (reg_rd) begin
      hit_d = 1'b1;
      case (reg_addr)
        `HSR_ADDR_MAKER_HI: rdata_d = `HSR_MAKER_UPPER_DEFAULT;
        `HSR_ADDR_TEMP_HI: rdata_d = temp_q[15:8];
        `HSR_ADDR_TEMP_LO: rdata_d = temp_q[7:0];
        `HSR_ADDR_XAXIS_HI: rdata_d = xaxis_q[15:8];
        `HSR_ADDR_XAXIS_LO: rdata_d = xaxis_q[7:0];
        `HSR_ADDR_YAXIS_HI: rdata_d = yaxis_q[15:8];
        `HSR_ADDR_YAXIS_LO: rdata_d = yaxis_q[7:0];
        `HSR_ADDR_ZAXIS_HI: rdata_d = zaxis_q[15:8];
        `HSR_ADDR_ZAXIS_LO: rdata_d = zaxis_q[7:0];
        `HSR_ADDR_CONV_STATE: rdata_d = status_byte;
        `HSR_ADDR_ANGLE_HI: rdata_d = angle_q[15:8];
        `HSR_ADDR_ANGLE_LO: rdata_d = angle_q[7:0];
        `HSR_ADDR_MAGNITUDE: rdata_d = mag_q;
        default: begin
          rdata_d = `HSR_RST_BYTE;
          hit_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= `HSR_RST_BYTE;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;
endmodule
`default_nettype wire

// >>> design/hsr_defines.svh
// Constants for the hall sensor result readout block.
// Assumes an 8-bit register port driven by a serial-bus front end elsewhere.
//
// Summary of operation
// - Temperature result is 16 bits, high byte then low byte, read only.
// - X axis result is 16 bits in two consecutive read-only bytes.
// - Y axis result is 16 bits in two consecutive read-only bytes.
// - Z axis result is 16 bits in two consecutive read-only bytes.
// - Status bits 7..5 hold a read-only rolling count of completed sets.
// - Status bit 4 sets on power-on reset, clears when host writes one.
// - Status bit 1 reads one while any internal diagnostic fails.
// - Status bit 0 reads one when a full data set is ready.
// - Angle spans 0 to 360 degrees in low 13 bits of angle pair.
// - Low four angle bits are sixteenths of a degree.
// - An 8-bit read-only vector magnitude accompanies angle measurement.
// - Upper byte of the maker code is read only; no low byte is mapped, so 0x0E reads as unmapped.
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH

`define HSR_ADDR_MAKER_HI 8'h0F
`define HSR_ADDR_TEMP_HI 8'h10
`define HSR_ADDR_TEMP_LO 8'h11
`define HSR_ADDR_XAXIS_HI 8'h12
`define HSR_ADDR_XAXIS_LO 8'h13
`define HSR_ADDR_YAXIS_HI 8'h14
`define HSR_ADDR_YAXIS_LO 8'h15
`define HSR_ADDR_ZAXIS_HI 8'h16
`define HSR_ADDR_ZAXIS_LO 8'h17
`define HSR_ADDR_CONV_STATE 8'h18
`define HSR_ADDR_ANGLE_HI 8'h19
`define HSR_ADDR_ANGLE_LO 8'h1A
`define HSR_ADDR_MAGNITUDE 8'h1B

`define HSR_RST_RESULT 16'h0000
`define HSR_RST_BYTE 8'h00
`define HSR_RST_COUNT 3'h0
// Arbitrary neutral identification value
`define HSR_MAKER_UPPER_DEFAULT 8'hA5

`define HSR_ST_COUNT_HI 7
`define HSR_ST_COUNT_LO 5
`define HSR_ST_POR 4
`define HSR_ST_DIAG 1
`define HSR_ST_READY 0

`define HSR_ANGLE_BITS 13
`define HSR_ANGLE_MAX 13'h1680
`define HSR_CH_TEMP 0
`define HSR_CH_XAXIS 1
`define HSR_CH_YAXIS 2
`define HSR_CH_ZAXIS 3
`define HSR_CH_ANGLE 4

`endif

// >>> design/hsr_pkg.sv
// Types for the hall sensor result readout block.
// Assumes hsr_defines.svh for all numeric constants.
package hsr_pkg;
  typedef logic [15:0] hsr_word_t;
  typedef logic [7:0] hsr_byte_t;
  typedef enum logic [1:0] {
    HSR_IDLE = 2'b00,
    HSR_LATCH = 2'b01
  } hsr_state_t;
endpackage

// >>> design/hsr_result_reg.sv
// One 16-bit result holder loaded when a set completes.
// Assumes load pulses come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "hsr_defines.svh"
module hsr_result_reg (
  input wire logic mclk,
  input wire logic reset,
  input wire logic load,
  input wire hsr_pkg::hsr_word_t din,
  output var hsr_pkg::hsr_word_t dout
);
  import hsr_pkg::*;
  hsr_word_t val_d;
  hsr_word_t val_q;

  always_comb begin
    val_d = val_q;
    if (load) begin
      val_d = din;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      val_q <= `HSR_RST_RESULT;
    end else begin
      val_q <= val_d;
    end
  end

  assign dout = val_q;
endmodule
`default_nettype wire

// >>> bench/hsr_readout_sva.sv
// Checker on the readout register and engine ports.
// Assumes one clock and a bind onto hsr_readout.
`timescale 1ns/1ps
`default_nettype none
`include "hsr_defines.svh"
module hsr_readout_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic set_done,
  input wire logic conv_busy,
  input wire logic [4:0] chan_enable,
  input wire hsr_pkg::hsr_word_t temperature_channel_value,
  input wire logic data_ready
);
  import hsr_pkg::*;
  // ------
  // Rules
  // ------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_MISS: assert property (
    reg_rd && reg_addr > 8'h1b |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not empty");
  AST_MAKER: assert property (
    reg_rd && reg_addr == 8'h0f |=> reg_hit && reg_rdata == 8'ha5)
    else $error("maker byte wrong");
  AST_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("read data moved");
  AST_READY: assert property (set_done |=> data_ready)
    else $error("ready missing");
  AST_BUSY: assert property (
    conv_busy && !set_done |=> !data_ready)
    else $error("ready kept while busy");
  AST_POR: assert property (
    reg_wr && reg_addr == `HSR_ADDR_CONV_STATE && reg_wdata[`HSR_ST_POR]
    ##1 !reg_wr ##1 reg_rd && reg_addr == `HSR_ADDR_CONV_STATE
    |=> !reg_rdata[`HSR_ST_POR])
    else $error("reset flag kept");
  AST_ANGLE: assert property (
    reg_rd && reg_addr == 8'h19 |=> reg_rdata <= 8'h16)
    else $error("angle past full turn");
  AST_TEMP: assert property (
    set_done && chan_enable[0] ##1 !set_done ##1 reg_rd
    && reg_addr == 8'h10 |=> {reg_rdata, 8'h00} ==
    ($past(temperature_channel_value, 3) & 16'hff00))
    else $error("temperature not loaded");
  cover property (set_done);
  cover property (reg_wr && reg_addr == 8'h18);
  cover property (reg_rd && reg_addr > 8'h1b);
endmodule
bind hsr_readout hsr_readout_sva i_hsr_readout_sva (
  .mclk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_hit, .set_done, .conv_busy, .chan_enable,
  .temperature_channel_value, .data_ready);
`default_nettype wire

// >>> bench/hsr_host.sv
// Host model issuing byte reads and writes.
// Assumes a one-cycle registered read answer.
`timescale 1ns/1ps
`default_nettype none
module hsr_host (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic h);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Stale address must not look valid
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
  // Diagnostic bit is meaningless while the supply sags, so mask it
  task automatic status_rd(input logic supply_low, output logic [7:0] d);
    logic h;
    rd(8'h18, d, h);
    if (supply_low) d[1] = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
endmodule
`default_nettype wire

// >>> bench/test_hsr_readout.sv
// Bench for the readout, register model kept in integers.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module test_hsr_readout;
  import hsr_pkg::*;
  logic mclk, reset, set_done, conv_busy, reg_wr, reg_rd, reg_hit, h;
  logic data_ready;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [4:0] chan_enable;
  logic [3:0] dg;
  hsr_word_t v [5];
  hsr_byte_t mag_in;
  int bad_count, checks_done, cyc, cnt, por, rdy, mag;
  int r [5];
  hsr_readout i_hsr_readout (.mclk, .reset, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_hit, .set_done, .conv_busy, .chan_enable,
    .temperature_channel_value(v[0]), .xaxis_field_value(v[1]),
    .yaxis_field_value(v[2]), .zaxis_field_value(v[3]),
    .angle_in(v[4][12:0]), .magnitude_in(mag_in), .diag_supply_low(dg[0]),
    .diag_memory_crc(dg[1]), .diag_int_pin(dg[2]), .diag_clock(dg[3]),
    .data_ready);
  hsr_host i_hsr_host (.mclk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_hit);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] ex(input int a);
    case (a)
      15: ex = 8'ha5;
      24: ex = 8'(cnt * 32 + por * 16 + (dg != 0) * 2 + rdy);
      25: ex = 8'(r[4] >> 8);
      26: ex = 8'(r[4]);
      27: ex = 8'(mag);
      default: ex = (a > 15 && a < 24) ?
        8'(r[a / 2 - 8] >> 8 * (1 - a % 2)) : 8'h00;
    endcase
  endfunction
  task automatic sweep();
    for (int a = 14; a < 29; a++) begin
      i_hsr_host.rd(8'(a), d, h);
      chk(d, ex(a));
      chk({7'h0, h}, 8'(a > 14 && a < 28));
    end
  endtask
  task automatic conv();
    @(posedge mclk);
    chan_enable <= 5'($urandom);
    v <= '{16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
      16'($urandom % 8192)};
    mag_in <= 8'($urandom);
    dg <= 4'($urandom);
    set_done <= 1'b1;
    @(posedge mclk);
    set_done <= 1'b0;
    for (int k = 0; k < 5; k++) if (chan_enable[k]) r[k] = v[k];
    // Angles past the full turn read back as exactly 360 degrees
    if (r[4] > 360 * 16) r[4] = 360 * 16;
    if (chan_enable[4]) mag = mag_in;
    cnt = (cnt + 1) % 8;
    rdy = 1;
    #1;
    chk({7'h0, data_ready}, 8'h01);
    i_hsr_host.rd(8'h10, d, h);
    chk(d, ex(16));
    i_hsr_host.status_rd(dg[0], d);
    chk(d, ex(24) & ~{6'h00, dg[0], 1'b0});
    @(posedge mclk);
    conv_busy <= 1'($urandom);
    @(posedge mclk);
    rdy = rdy & ~conv_busy;
    conv_busy <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {reset, set_done, conv_busy, chan_enable, dg, mag_in} = 20'h8_0000;
    v = '{default: 0};
    por = 1;
    void'($urandom(42));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    sweep();
    $display("reset values done");
    i_hsr_host.wr(8'h10, 8'hff);
    i_hsr_host.wr(8'h18, 8'hef);
    sweep();
    i_hsr_host.wr(8'h18, 8'h10);
    por = 0;
    i_hsr_host.rd(8'h18, d, h);
    chk(d, ex(24));
    sweep();
    $display("writes done");
    repeat (9) begin
      conv();
      sweep();
    end
    $display("conversion sets done");
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    r = '{default: 0};
    {cnt, por, rdy, mag} = {32'd0, 32'd1, 32'd0, 32'd0};
    sweep();
    $display("second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
